/* File: call_return_pkg.sv */
// Constants and types shared by the call/return sequencer and its stack
//
// What this block does
// - Relative call: top five bits 11011, low 11 bits signed word offset.
// - Relative call first pushes address plus 2 onto the return stack.
// - Relative call then jumps to address plus 2 plus twice the offset.
// - Relative call: two cycles, one word, idle second cycle, no flag change.
// - Software reset: one cycle, core registers and stack pointer back to reset values; stack entries keep their contents.
// - Return from interrupt: two cycles, pops top of stack into counter.
// - Return from interrupt sets high or low interrupt enable, never both.
// - Return from interrupt with select bit restores accumulator, flags, bank.
// - Return with literal loads accumulator, pops counter, two cycles.
// - Returns leave the upper and high counter latches untouched.
// - Return from subroutine: two cycles, pops stack into counter, flags written only with select bit set.
// - Return from subroutine with select bit set restores shadow copies.
// - Push moves old top one level down; pop makes previous entry the top.
package call_return_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int PC_W        = 21;
  localparam int INSTR_W     = 16;
  localparam int ACC_W       = 8;
  localparam int FLAG_W      = 5;
  localparam int BANK_W      = 4;
  localparam int STACK_DEPTH = 31;
  localparam int STACK_PTR_W = 5;
  localparam int OFFSET_W    = 11;

  // ----------------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------------
  localparam logic [INSTR_W-1:0] RELATIVE_CALL_MASK  = 16'hF800;
  localparam logic [INSTR_W-1:0] RELATIVE_CALL_MATCH = 16'hD800;
  localparam logic [INSTR_W-1:0] RETURN_IRQ_MASK     = 16'hFFFE;
  localparam logic [INSTR_W-1:0] RETURN_IRQ_MATCH    = 16'h0010;
  localparam logic [INSTR_W-1:0] RETURN_SUB_MASK     = 16'hFFFE;
  localparam logic [INSTR_W-1:0] RETURN_SUB_MATCH    = 16'h0012;
  localparam logic [INSTR_W-1:0] RETURN_LIT_MASK     = 16'hFF00;
  localparam logic [INSTR_W-1:0] RETURN_LIT_MATCH    = 16'h0C00;
  localparam logic [INSTR_W-1:0] SOFT_RESET_MASK     = 16'hFFFF;
  localparam logic [INSTR_W-1:0] SOFT_RESET_MATCH    = 16'h00FF;
  localparam int                 SHADOW_SEL_BIT      = 0;

  // ----------------------------------------------------------------------
  // Counter step and reset values
  // ----------------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_STEP       = 21'h000002;
  localparam logic [PC_W-1:0]    PC_RESET      = 21'h000000;
  localparam logic [ACC_W-1:0]   ACC_RESET     = 8'h00;
  localparam logic [FLAG_W-1:0]  FLAG_RESET    = 5'h00;
  localparam logic [BANK_W-1:0]  BANK_RESET    = 4'h0;

  typedef enum logic {ST_EXEC, ST_DISCARD} seq_state_t;

endpackage

/* File: return_stack.sv */
// Hardware return stack holding program counter values
`timescale 1ns/100ps
module return_stack
(
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   clear_i,
  input  wire logic                                   push_i,
  input  wire logic                                   pop_i,
  input  wire logic [call_return_pkg::PC_W-1:0]       push_data_i,
  output logic      [call_return_pkg::PC_W-1:0]       top_o,
  output logic      [call_return_pkg::STACK_PTR_W-1:0] depth_o,
  output logic                                        full_o,
  output logic                                        empty_o
);

  typedef struct packed
  {
    logic [call_return_pkg::STACK_DEPTH-1:0][call_return_pkg::PC_W-1:0] mem;
    logic [call_return_pkg::STACK_PTR_W-1:0]                          ptr;
  } stack_t;

  localparam logic [call_return_pkg::STACK_PTR_W-1:0] PTR_FULL =
    5'h1F;

  stack_t q;
  stack_t d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (clear_i)
    begin
      d.ptr = '0;
    end
    else if (push_i && (q.ptr != PTR_FULL))
    begin
      // New entry above, older entries stay one level down
      d.mem[q.ptr] = push_data_i;
      d.ptr        = q.ptr + 5'h01;
    end
    else if (pop_i && (q.ptr != '0))
    begin
      // Previous entry becomes the top
      d.ptr = q.ptr - 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign empty_o = (q.ptr == '0);
  assign full_o  = (q.ptr == PTR_FULL);
  assign depth_o = q.ptr;
  assign top_o   = empty_o ? call_return_pkg::PC_RESET
                           : q.mem[q.ptr - 5'h01];

endmodule

/* File: call_return_sequencer.sv */
// Call, return and software-reset decode and execution sequencer
`timescale 1ns/100ps
module call_return_sequencer
(
  input  wire logic                                    sys_clk_i,
  input  wire logic                                    rst_i,
  input  wire logic [call_return_pkg::INSTR_W-1:0]     instr_i,
  input  wire logic                                    instr_valid_i,
  input  wire logic                                    high_priority_active_i,
  input  wire logic [call_return_pkg::ACC_W-1:0]       accumulator_shadow_i,
  input  wire logic [call_return_pkg::FLAG_W-1:0]      flag_shadow_i,
  input  wire logic [call_return_pkg::BANK_W-1:0]      bank_select_shadow_i,
  output logic      [call_return_pkg::PC_W-1:0]        fetch_addr_o,
  output logic                                         discard_o,
  output logic      [call_return_pkg::PC_W-1:0]        top_of_stack_o,
  output logic      [call_return_pkg::STACK_PTR_W-1:0] stack_depth_o,
  output logic                                         stack_full_o,
  output logic                                         stack_empty_o,
  output logic                                         acc_we_o,
  output logic      [call_return_pkg::ACC_W-1:0]       acc_wdata_o,
  output logic                                         flag_we_o,
  output logic      [call_return_pkg::FLAG_W-1:0]      flag_wdata_o,
  output logic                                         bank_select_we_o,
  output logic      [call_return_pkg::BANK_W-1:0]      bank_select_wdata_o,
  output logic                                         high_irq_enable_set_o,
  output logic                                         low_irq_enable_set_o,
  output logic                                         soft_reset_o
);

  typedef struct packed
  {
    call_return_pkg::seq_state_t              state;
    logic [call_return_pkg::PC_W-1:0]         pc;
    logic                                     acc_we;
    logic [call_return_pkg::ACC_W-1:0]        acc_wdata;
    logic                                     flag_we;
    logic [call_return_pkg::FLAG_W-1:0]       flag_wdata;
    logic                                     bank_we;
    logic [call_return_pkg::BANK_W-1:0]       bank_wdata;
    logic                                     hi_set;
    logic                                     lo_set;
    logic                                     soft_reset;
  } core_t;

  localparam core_t CORE_RESET = '{
    state:      call_return_pkg::ST_EXEC,
    pc:         call_return_pkg::PC_RESET,
    acc_we:     1'b0,
    acc_wdata:  call_return_pkg::ACC_RESET,
    flag_we:    1'b0,
    flag_wdata: call_return_pkg::FLAG_RESET,
    bank_we:    1'b0,
    bank_wdata: call_return_pkg::BANK_RESET,
    hi_set:     1'b0,
    lo_set:     1'b0,
    soft_reset: 1'b0
  };

  core_t q;
  core_t d;

  logic                                     push;
  logic                                     pop;
  logic                                     stack_clear;
  logic [call_return_pkg::PC_W-1:0]         push_data;
  logic [call_return_pkg::PC_W-1:0]         stack_top;
  logic                                     is_call;
  logic                                     is_ret_irq;
  logic                                     is_ret_sub;
  logic                                     is_ret_lit;
  logic                                     is_soft_reset;
  logic                                     exec_ok;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic op_match
  (
    input logic [call_return_pkg::INSTR_W-1:0] word,
    input logic [call_return_pkg::INSTR_W-1:0] mask,
    input logic [call_return_pkg::INSTR_W-1:0] match
  );
    op_match = ((word & mask) == match);
  endfunction

  // Twice the sign-extended word offset
  function automatic logic [call_return_pkg::PC_W-1:0] call_offset
  (
    input logic [call_return_pkg::INSTR_W-1:0] word
  );
    call_offset = {{9{word[10]}}, word[10:0], 1'b0};
  endfunction

  assign exec_ok       = (q.state == call_return_pkg::ST_EXEC) &&
                         instr_valid_i;
  assign is_call       = op_match(instr_i,
                                  call_return_pkg::RELATIVE_CALL_MASK,
                                  call_return_pkg::RELATIVE_CALL_MATCH);
  assign is_ret_irq    = op_match(instr_i,
                                  call_return_pkg::RETURN_IRQ_MASK,
                                  call_return_pkg::RETURN_IRQ_MATCH);
  assign is_ret_sub    = op_match(instr_i,
                                  call_return_pkg::RETURN_SUB_MASK,
                                  call_return_pkg::RETURN_SUB_MATCH);
  assign is_ret_lit    = op_match(instr_i,
                                  call_return_pkg::RETURN_LIT_MASK,
                                  call_return_pkg::RETURN_LIT_MATCH);
  assign is_soft_reset = op_match(instr_i,
                                  call_return_pkg::SOFT_RESET_MASK,
                                  call_return_pkg::SOFT_RESET_MATCH);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d             = q;
    d.acc_we      = 1'b0;
    d.flag_we     = 1'b0;
    d.bank_we     = 1'b0;
    d.hi_set      = 1'b0;
    d.lo_set      = 1'b0;
    d.soft_reset  = 1'b0;
    push          = 1'b0;
    pop           = 1'b0;
    stack_clear   = 1'b0;
    push_data     = q.pc + call_return_pkg::PC_STEP;
    unique case (q.state)
      call_return_pkg::ST_EXEC:
      begin
        if (instr_valid_i)
        begin
          d.pc = q.pc + call_return_pkg::PC_STEP;
          if (is_call)
          begin
            push    = 1'b1;
            d.pc    = q.pc + call_return_pkg::PC_STEP +
                      call_offset(instr_i);
            d.state = call_return_pkg::ST_DISCARD;
          end
          else if (is_ret_irq || is_ret_sub)
          begin
            // Counter loaded from the stack top, shadows on select bit; latches are not ours
            pop     = 1'b1;
            d.pc    = stack_top;
            d.state = call_return_pkg::ST_DISCARD;
            if (instr_i[call_return_pkg::SHADOW_SEL_BIT])
            begin
              d.acc_we     = 1'b1;
              d.acc_wdata  = accumulator_shadow_i;
              d.flag_we    = 1'b1;
              d.flag_wdata = flag_shadow_i;
              d.bank_we    = 1'b1;
              d.bank_wdata = bank_select_shadow_i;
            end
            if (is_ret_irq)
            begin
              d.hi_set = high_priority_active_i;
              d.lo_set = !high_priority_active_i;
            end
          end
          else if (is_ret_lit)
          begin
            pop         = 1'b1;
            d.pc        = stack_top;
            d.acc_we    = 1'b1;
            d.acc_wdata = instr_i[call_return_pkg::ACC_W-1:0];
            d.state     = call_return_pkg::ST_DISCARD;
          end
          else if (is_soft_reset)
          begin
            // Whole core state back to reset values
            d            = CORE_RESET;
            d.soft_reset = 1'b1;
            stack_clear  = 1'b1;
          end
        end
      end
      call_return_pkg::ST_DISCARD:
      begin
        // Prefetched word dropped, nothing changes
        d.state = call_return_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= CORE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------
  return_stack u_stack
  (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .clear_i     (stack_clear),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (push_data),
    .top_o       (stack_top),
    .depth_o     (stack_depth_o),
    .full_o      (stack_full_o),
    .empty_o     (stack_empty_o)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign fetch_addr_o          = q.pc;
  assign discard_o             = (q.state == call_return_pkg::ST_DISCARD);
  assign top_of_stack_o        = stack_top;
  assign acc_we_o              = q.acc_we;
  assign acc_wdata_o           = q.acc_wdata;
  assign flag_we_o             = q.flag_we;
  assign flag_wdata_o          = q.flag_wdata;
  assign bank_select_we_o      = q.bank_we;
  assign bank_select_wdata_o   = q.bank_wdata;
  assign high_irq_enable_set_o = q.hi_set;
  assign low_irq_enable_set_o  = q.lo_set;
  assign soft_reset_o          = q.soft_reset;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  call_target_a: assert property (
    exec_ok && is_call |=>
      fetch_addr_o == $past(q.pc) + call_return_pkg::PC_STEP +
                      $past(call_offset(instr_i)))
    else $error("call target address wrong");

  call_push_a: assert property (
    exec_ok && is_call && !stack_full_o |=>
      top_of_stack_o == $past(q.pc) + call_return_pkg::PC_STEP &&
      stack_depth_o == $past(stack_depth_o) + 5'h01)
    else $error("call return address not pushed");

  call_timing_a: assert property (
    exec_ok && is_call |=> discard_o && !flag_we_o ##1 !discard_o)
    else $error("call not two cycles");

  soft_reset_a: assert property (
    exec_ok && is_soft_reset |=>
      soft_reset_o && fetch_addr_o == call_return_pkg::PC_RESET &&
      stack_empty_o && !discard_o ##1
      (!soft_reset_o || $past(exec_ok && is_soft_reset)))
    else $error("software reset not applied");

  ret_irq_pc_a: assert property (
    exec_ok && is_ret_irq |=>
      fetch_addr_o == $past(stack_top) && discard_o)
    else $error("irq return counter wrong");

  irq_enable_a: assert property (
    exec_ok && is_ret_irq |=>
      (high_irq_enable_set_o != low_irq_enable_set_o) &&
      high_irq_enable_set_o == $past(high_priority_active_i))
    else $error("irq enable not set once");

  shadow_restore_a: assert property (
    exec_ok && (is_ret_irq || is_ret_sub) |=>
      acc_we_o == $past(instr_i[0]) && flag_we_o == $past(instr_i[0]) &&
      bank_select_we_o == $past(instr_i[0]))
    else $error("shadow restore mismatch");

  ret_literal_a: assert property (
    exec_ok && is_ret_lit |=>
      acc_we_o && acc_wdata_o == $past(instr_i[7:0]) && !flag_we_o &&
      fetch_addr_o == $past(stack_top))
    else $error("literal return wrong");

  ret_sub_a: assert property (
    exec_ok && is_ret_sub && !stack_empty_o |=>
      fetch_addr_o == $past(stack_top) && !high_irq_enable_set_o &&
      !low_irq_enable_set_o && stack_depth_o == $past(stack_depth_o) - 5'h01)
    else $error("subroutine return wrong");

  discard_idle_a: assert property (
    discard_o |=> fetch_addr_o == $past(fetch_addr_o) && !acc_we_o &&
      !flag_we_o && !discard_o)
    else $error("discard cycle not idle");

  call_full_drop_a: assert property (
    exec_ok && is_call && stack_full_o |=>
      stack_full_o && top_of_stack_o == $past(top_of_stack_o))
    else $error("push on full stack not dropped");

  plain_step_a: assert property (
    exec_ok && !(is_call || is_ret_irq || is_ret_sub || is_ret_lit ||
      is_soft_reset) |=>
      fetch_addr_o == $past(fetch_addr_o) + call_return_pkg::PC_STEP &&
      !discard_o && !acc_we_o && !flag_we_o)
    else $error("plain word not single step");

  stall_hold_a: assert property (
    !discard_o && !instr_valid_i |=>
      fetch_addr_o == $past(fetch_addr_o) && !discard_o && !acc_we_o)
    else $error("stall moved the counter");

  call_seen_c:   cover property (exec_ok && is_call);
  full_push_c:   cover property (exec_ok && is_call && stack_full_o);
  shadow_irq_c:  cover property (exec_ok && is_ret_irq && instr_i[0]);
  literal_ret_c: cover property (exec_ok && is_ret_lit);
  soft_reset_c:  cover property (exec_ok && is_soft_reset);

endmodule

/* File: call_return_sequencer_tb.sv */
// Self-checking testbench for the call/return sequencer
`timescale 1ns/100ps
`define CHK(g, e, m) check_val(32'(g), 32'(e), m)
module call_return_sequencer_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        sys_clk_i              = 1'b0;
  logic        rst_i                  = 1'b1;
  logic [15:0] instr_i                = 16'h0000;
  logic        instr_valid_i          = 1'b0;
  logic        high_priority_active_i = 1'b0;
  logic [7:0]  acc_sh                 = 8'h5A;
  logic [4:0]  flag_sh                = 5'h15;
  logic [3:0]  bank_sh                = 4'hC;
  logic [20:0] fetch_addr_o;
  logic        discard_o;
  logic [20:0] top_of_stack_o;
  logic [4:0]  stack_depth_o;
  logic        stack_full_o;
  logic        stack_empty_o;
  logic        acc_we_o;
  logic [7:0]  acc_wdata_o;
  logic        flag_we_o;
  logic [4:0]  flag_wdata_o;
  logic        bank_select_we_o;
  logic [3:0]  bank_select_wdata_o;
  logic        high_irq_enable_set_o;
  logic        low_irq_enable_set_o;
  logic        soft_reset_o;
  int          bad_count              = 0;
  int          comparisons            = 0;
  logic [20:0] pc_m                   = 21'h000000;
  logic [20:0] stk_m[$];

  always #4 sys_clk_i = ~sys_clk_i;

  call_return_sequencer i_call_return_sequencer
  (
    .sys_clk_i              (sys_clk_i),
    .rst_i                  (rst_i),
    .instr_i                (instr_i),
    .instr_valid_i          (instr_valid_i),
    .high_priority_active_i (high_priority_active_i),
    .accumulator_shadow_i   (acc_sh),
    .flag_shadow_i          (flag_sh),
    .bank_select_shadow_i   (bank_sh),
    .fetch_addr_o           (fetch_addr_o),
    .discard_o              (discard_o),
    .top_of_stack_o         (top_of_stack_o),
    .stack_depth_o          (stack_depth_o),
    .stack_full_o           (stack_full_o),
    .stack_empty_o          (stack_empty_o),
    .acc_we_o               (acc_we_o),
    .acc_wdata_o            (acc_wdata_o),
    .flag_we_o              (flag_we_o),
    .flag_wdata_o           (flag_wdata_o),
    .bank_select_we_o       (bank_select_we_o),
    .bank_select_wdata_o    (bank_select_wdata_o),
    .high_irq_enable_set_o  (high_irq_enable_set_o),
    .low_irq_enable_set_o   (low_irq_enable_set_o),
    .soft_reset_o           (soft_reset_o)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check_val(input logic [31:0] g, input logic [31:0] e,
                           input string m);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Drive a word at the falling edge, let one rising edge take it
  task automatic step(input logic [15:0] w, input logic v);
    instr_i       = w;
    instr_valid_i = v;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  // Feed a call word into the discard slot; it must have no effect
  task automatic skip_slot;
    step(16'hD8FF, 1'b1);
    `CHK(discard_o, 1'b0, "discard after slot");
    `CHK(fetch_addr_o, pc_m, "pc after slot");
    `CHK(stack_depth_o, stk_m.size(), "depth after slot");
  endtask

  task automatic do_call(input logic [10:0] n);
    logic [20:0] tgt;
    tgt = pc_m + 21'h000002 + {{9{n[10]}}, n, 1'b0};
    stk_m.push_front(pc_m + 21'h000002);
    step(16'hD800 | {5'h00, n}, 1'b1);
    `CHK(fetch_addr_o, tgt, "call target");
    `CHK(top_of_stack_o, stk_m[0], "return address");
    `CHK(stack_depth_o, stk_m.size(), "depth after call");
    `CHK(discard_o, 1'b1, "call second cycle");
    `CHK({acc_we_o, flag_we_o, bank_select_we_o}, 3'h0, "call flags");
    pc_m = tgt;
    skip_slot();
  endtask

  task automatic ret_op(input logic [15:0] w, input logic hp);
    logic        irq;
    logic        rest;
    logic        lit;
    logic [20:0] tgt;
    irq  = (w[15:1] == 15'h0008);
    rest = (irq || w[15:1] == 15'h0009) && w[0];
    lit  = (w[15:8] == 8'h0C);
    tgt  = (stk_m.size() > 0) ? stk_m.pop_front() : 21'h000000;
    high_priority_active_i = hp;
    step(w, 1'b1);
    `CHK(fetch_addr_o, tgt, "return target");
    `CHK(stack_depth_o, stk_m.size(), "depth after pop");
    if (stk_m.size() > 0)
      `CHK(top_of_stack_o, stk_m[0], "new top");
    `CHK(discard_o, 1'b1, "return second cycle");
    `CHK(acc_we_o, rest | lit, "acc write");
    `CHK({flag_we_o, bank_select_we_o}, {2{rest}}, "restore");
    if (rest)
      `CHK({acc_wdata_o, flag_wdata_o, bank_select_wdata_o},
           {acc_sh, flag_sh, bank_sh}, "shadow data");
    if (lit)
      `CHK(acc_wdata_o, w[7:0], "literal");
    `CHK(high_irq_enable_set_o, irq & hp, "high enable");
    `CHK(low_irq_enable_set_o, irq & ~hp, "low enable");
    pc_m = tgt;
    skip_slot();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    `CHK(fetch_addr_o, 21'h000000, "reset pc");
    `CHK(stack_depth_o, 5'h00, "reset depth");
    `CHK({stack_empty_o, stack_full_o}, 2'h2, "reset stack");
    `CHK({discard_o, soft_reset_o, acc_we_o}, 3'h0, "reset strobes");
    $display("test reset done");
  endtask

  task automatic t_call_bounds;
    do_call(11'h3FF);
    do_call(11'h400);
    $display("test call bounds done");
  endtask

  task automatic t_returns;
    ret_op(16'h0CA5, 1'b0);
    ret_op(16'h0013, 1'b0);
    $display("test returns done");
  endtask

  task automatic t_irq_returns;
    do_call(11'h000);
    do_call(11'h7FF);
    do_call(11'h005);
    ret_op(16'h0011, 1'b1);
    ret_op(16'h0010, 1'b0);
    ret_op(16'h0012, 1'b0);
    ret_op(16'h0012, 1'b0);
    $display("test irq returns done");
  endtask

  task automatic t_stall_plain;
    step(16'h0012, 1'b0);
    `CHK(fetch_addr_o, pc_m, "stalled pc");
    `CHK(discard_o, 1'b0, "stalled discard");
    step(16'h0000, 1'b1);
    pc_m = pc_m + 21'h000002;
    `CHK(fetch_addr_o, pc_m, "plain step");
    $display("test stall done");
  endtask

  task automatic t_soft_reset;
    do_call(11'h003);
    do_call(11'h010);
    step(16'h00FF, 1'b1);
    `CHK(soft_reset_o, 1'b1, "soft reset pulse");
    `CHK(fetch_addr_o, 21'h000000, "soft reset pc");
    `CHK(stack_depth_o, 5'h00, "soft reset stack");
    `CHK(discard_o, 1'b0, "soft reset one cycle");
    stk_m.delete();
    step(16'h0000, 1'b1);
    `CHK(soft_reset_o, 1'b0, "soft reset ends");
    `CHK(fetch_addr_o, 21'h000002, "word after reset");
    pc_m = 21'h000002;
    $display("test soft reset done");
  endtask

  // Fill the stack, push once more, then drain it
  task automatic t_stack_full;
    logic [20:0] top;
    repeat (31)
      do_call(11'h000);
    `CHK(stack_full_o, 1'b1, "stack full");
    top = stk_m[0];
    step(16'hD800, 1'b1);
    pc_m = pc_m + 21'h000002;
    `CHK(fetch_addr_o, pc_m, "call on full stack");
    `CHK(top_of_stack_o, top, "full top kept");
    `CHK(stack_depth_o, 5'h1F, "full depth kept");
    skip_slot();
    repeat (31)
      ret_op(16'h0012, 1'b0);
    `CHK(stack_empty_o, 1'b1, "stack drained");
    $display("test stack full done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge sys_clk_i);
    t_reset();
    rst_i = 1'b0;
    t_call_bounds();
    t_returns();
    t_irq_returns();
    t_stall_plain();
    t_stack_full();
    t_soft_reset();
    give_verdict();
  end

  initial
  begin
    #200000;
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
